// ==== verilog/bwd_consts.svh ====
// constants of the bus width, dram timing and idle register bank
// assumes inclusion by bare name from the modules
`ifndef BWD_CONSTS_SVH
`define BWD_CONSTS_SVH

// wishbone byte offsets
`define BWD_ADR_WIDTH_CFG 8'h00
`define BWD_ADR_DRAM_CFG 8'h04
`define BWD_ADR_IDLE_CFG 8'h08
`define BWD_ADR_STATUS 8'h0C
`define BWD_ADR_MSB 7

// reset values
`define BWD_RST_WIDTH_CFG 16'h3FF0
`define BWD_RST_DRAM_CFG 16'h0000
`define BWD_RST_IDLE_CFG 16'h3FF3
`define BWD_RST_AREA_WIDTH 10'h3FF

// writable bits, the rest read zero
`define BWD_WMASK_WIDTH_CFG 16'h3FF0
`define BWD_WMASK_DRAM_CFG 16'hBF3F
`define BWD_WMASK_IDLE_CFG 16'h3FF3

// field positions
`define BWD_EXT_BIT 15
`define BWD_A3_FIELDS_MSB 13
`define BWD_A3_FIELDS_LSB 8
`define BWD_A2_FIELDS_MSB 5
`define BWD_A2_FIELDS_LSB 0
`define BWD_WIDTH_MSB 13
`define BWD_WIDTH_LSB 4

// width codes
`define BWD_WID_RSVD 2'h0
`define BWD_WID_32 2'h3

// area 2/3 memory type codes
`define BWD_MT_A3_DRAM 3'h4
`define BWD_MT_A23_DRAM 3'h5

// timing counts in cycles
`define BWD_EXT_SINGLE_MIN 3'h2
`define BWD_EXT_BURST_PITCH 3'h1
`define BWD_RCD_BASE 3'h1
`define BWD_RAS_BASE 3'h2
`define BWD_TPC_BASE 4'h1
`define BWD_TPC_SR_BASE 4'h2
`define BWD_TPC_SR_STEP 4'h3
`define BWD_TPC_A3_CLAMP 4'h2
`define BWD_NO_IDLE 2'h0

`endif

// ==== verilog/bwd_pkg.sv ====
// types shared by the register bank and its timing selector
// assumes bwd_consts.svh on the include path
package bwd_pkg;
	// precharge, ras-cas delay, refresh ras fields in register order
	typedef struct packed {
		logic [1:0] tpc;
		logic [1:0] rcd;
		logic [1:0] tras;
	} bwd_ctl_fields_t;

	// decoded dram timing in cycles
	typedef struct packed {
		logic [3:0] precharge;
		logic [2:0] ras_cas;
		logic [2:0] refresh_ras;
		logic       rsvd_code;
	} bwd_dram_timing_t;

	// start of an external bus cycle
	typedef struct packed {
		logic       start;
		logic [2:0] area;
		logic       write;
	} bwd_bus_cycle_t;
endpackage

// ==== verilog/bwd_dram_timing_sel.sv ====
// picks and decodes dram timing for one area of the dma-side controller
// assumes the caller registers the result
`timescale 1ns/1ps
`include "bwd_consts.svh"
module bwd_dram_timing_sel import bwd_pkg::*; #(
	parameter bit AREA2_STYLE = 1'b0
) (
	// selection
	input  wire logic       ext_mode,
	input  wire logic       is_dram,
	input  wire logic       after_self_refresh,
	// field sources
	input  wire bwd_ctl_fields_t ext_fields,
	input  wire bwd_ctl_fields_t cpu_fields,
	// result
	output bwd_dram_timing_t     timing
);
	bwd_ctl_fields_t f;
	logic            use_ext;

	always_comb begin
		use_ext = ext_mode & is_dram;
		f = use_ext ? ext_fields : cpu_fields;
		timing.ras_cas = {1'b0, f.rcd} + `BWD_RCD_BASE;
		timing.refresh_ras = {1'b0, f.tras} + `BWD_RAS_BASE;
		timing.rsvd_code = 1'b0;
		if (AREA2_STYLE) begin
			if (after_self_refresh) begin
				timing.precharge = `BWD_TPC_SR_BASE + `BWD_TPC_SR_STEP * {2'h0, f.tpc};
			end else begin
				timing.precharge = {2'h0, f.tpc} + `BWD_TPC_BASE;
			end
		end else begin
			// reserved codes clamp to the longer gap rather than a short one
			timing.rsvd_code = use_ext & f.tpc[1];
			if (timing.rsvd_code) begin
				timing.precharge = `BWD_TPC_A3_CLAMP;
			end else begin
				timing.precharge = {2'h0, f.tpc} + `BWD_TPC_BASE;
			end
		end
	end
endmodule

// ==== verilog/bwd_regs.sv ====
// bus width, extended dram timing and intercycle idle register bank
// assumes a classic wishbone master and bus cycle logic on REF_CLK
// Summary of operation
// - width register resets to 3FF0 on power-on only; kept otherwise.
// - width bits 15,14,3-0 and idle bits 15,14,3,2 read zero.
// - width code per area: reserved, 8, 16, 32; 32 reserved with port pins.
// - dram timing register clears on power-on only; kept otherwise.
// - extended flag affects dma side only; off means cpu-side settings.
// - extended: single access two cycles minimum, burst pitch one cycle.
// - area 3 precharge replaces memory control field: 1, 2, reserved.
// - area 3 ras-cas delay replaces memory control field: 1 to 4.
// - area 3 refresh ras assert time: 2 to 5 cycles.
// - area 2 precharge: 1 to 4, or 2,5,8,11 after self refresh.
// - area 2 ras-cas delay replaces dram control field: 1 to 4.
// - area 2 refresh ras assert time: 2 to 5 cycles.
// - dram timing bits 14, 7, 6 always read zero.
// - idle register resets to 3FF3 on power-on only; kept otherwise.
// - idle cycles on leaving an area or on read then write there.
// - idle field code: 00 and 01 one, 10 two, 11 three cycles.
// - dram timing applies only to dram areas per memory type 100/101.
//
// Local design decisions: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "bwd_consts.svh"
module bwd_regs import bwd_pkg::*; (
	// clock and power-on reset
	input  wire logic        REF_CLK,
	input  wire logic        SRST,
	// wishbone slave
	input  wire logic        WB_CYC_I,
	input  wire logic        WB_STB_I,
	input  wire logic        WB_WE_I,
	input  wire logic [7:0]  WB_ADR_I,
	input  wire logic [3:0]  WB_SEL_I,
	input  wire logic [31:0] WB_DAT_I,
	output logic      [31:0] WB_DAT_O,
	output logic             WB_ACK_O,
	// configuration from the rest of the controller
	input  wire logic        PORT_AB_USED,
	input  wire logic [2:0]  AREA23_MEMORY_TYPE,
	input  wire bwd_ctl_fields_t MEMORY_CONTROL_FIELDS,
	input  wire bwd_ctl_fields_t DRAM_CONTROL_FIELDS,
	input  wire logic        AFTER_SELF_REFRESH,
	// bus cycle starts
	input  wire bwd_bus_cycle_t BUS_CYCLE,
	input  wire logic        DMA_CYCLE_START,
	// settings for the bus cycle generators
	output logic      [9:0]  AREA_WIDTH,
	output logic             WIDTH_RESERVED,
	output logic      [1:0]  IDLE_CYCLES,
	output logic             IDLE_INSERT,
	output logic             DMA_EXTENDED,
	output logic      [2:0]  DMA_SINGLE_MIN,
	output logic      [2:0]  DMA_BURST_PITCH,
	output bwd_dram_timing_t DMA_AREA3_TIMING,
	output bwd_dram_timing_t DMA_AREA2_TIMING
);
	// register state
	logic [15:0] width_cfg_ff;
	logic [15:0] dram_cfg_ff;
	logic [15:0] idle_cfg_ff;
	logic [15:0] nxt_width_cfg;
	logic [15:0] nxt_dram_cfg;
	logic [15:0] nxt_idle_cfg;
	logic        ack_ff;
	logic [31:0] rdata_ff;
	// bus decode
	logic        req;
	logic        wr_take;
	logic [15:0] lane_mask;
	logic [15:0] rd_word;
	// live decode
	logic        a3_dram;
	logic        a2_dram;
	logic        width_bad;
	logic [3:0]  status_word;
	bwd_dram_timing_t a3_timing;
	bwd_dram_timing_t a2_timing;
	// idle tracking
	logic        prev_valid_ff;
	logic [2:0]  prev_area_ff;
	logic        prev_read_ff;
	logic        need_idle;
	logic [1:0]  idle_code;
	// snapshots
	logic [9:0]  area_width_ff;
	logic        width_rsvd_ff;
	logic [1:0]  idle_cycles_ff;
	logic        idle_insert_ff;
	logic        dma_ext_ff;
	logic [2:0]  dma_single_ff;
	logic [2:0]  dma_pitch_ff;
	bwd_dram_timing_t dma_a3_ff;
	bwd_dram_timing_t dma_a2_ff;

	// idle field of an area; areas with no field insert nothing
	function automatic logic [1:0] idle_field(input logic [15:0] cfg, input logic [2:0] area);
		logic [1:0] code;
		code = `BWD_NO_IDLE;
		case (area)
			3'h0: code = cfg[1:0];
			3'h2: code = cfg[5:4];
			3'h3: code = cfg[7:6];
			3'h4: code = cfg[9:8];
			3'h5: code = cfg[11:10];
			3'h6: code = cfg[13:12];
			default: code = `BWD_NO_IDLE;
		endcase
		return code;
	endfunction

	// code 00 and 01 both mean one idle cycle
	function automatic logic [1:0] idle_count(input logic [1:0] code);
		logic [1:0] n;
		n = (code == 2'h0) ? 2'h1 : code;
		return n;
	endfunction

	// any area width code that must not be programmed
	function automatic logic width_check(input logic [15:0] cfg, input logic port_used);
		logic       bad;
		logic [1:0] c;
		bad = 1'b0;
		c = 2'h0;
		for (int n = 2; n <= 6; n++) begin
			c = cfg[2*n +: 2];
			if (c == `BWD_WID_RSVD) begin
				bad = 1'b1;
			end
			if (port_used && (c == `BWD_WID_32)) begin
				bad = 1'b1;
			end
		end
		return bad;
	endfunction

	// wishbone request decode
	always_comb begin
		req = WB_CYC_I & WB_STB_I;
		// write lands on the edge where the master sees ack
		wr_take = req & WB_WE_I & ack_ff;
		lane_mask = {{8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
	end

	// next register values with byte lanes and fixed-zero bits
	always_comb begin
		nxt_width_cfg = width_cfg_ff;
		nxt_dram_cfg = dram_cfg_ff;
		nxt_idle_cfg = idle_cfg_ff;
		if (wr_take) begin
			case (WB_ADR_I)
				`BWD_ADR_WIDTH_CFG: begin
					nxt_width_cfg = ((width_cfg_ff & ~lane_mask) | (WB_DAT_I[15:0] & lane_mask))
						& `BWD_WMASK_WIDTH_CFG;
				end
				`BWD_ADR_DRAM_CFG: begin
					nxt_dram_cfg = ((dram_cfg_ff & ~lane_mask) | (WB_DAT_I[15:0] & lane_mask))
						& `BWD_WMASK_DRAM_CFG;
				end
				`BWD_ADR_IDLE_CFG: begin
					nxt_idle_cfg = ((idle_cfg_ff & ~lane_mask) | (WB_DAT_I[15:0] & lane_mask))
						& `BWD_WMASK_IDLE_CFG;
				end
				default: begin
					nxt_width_cfg = width_cfg_ff;
				end
			endcase
		end
	end

	// only power-on reset touches these; manual reset and standby never reach here
	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			width_cfg_ff <= `BWD_RST_WIDTH_CFG;
		end else begin
			width_cfg_ff <= nxt_width_cfg;
		end
	end

	// written once at init by software, but any later write is still honoured
	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			dram_cfg_ff <= `BWD_RST_DRAM_CFG;
		end else begin
			dram_cfg_ff <= nxt_dram_cfg;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			idle_cfg_ff <= `BWD_RST_IDLE_CFG;
		end else begin
			idle_cfg_ff <= nxt_idle_cfg;
		end
	end

	// live status
	always_comb begin
		a3_dram = (AREA23_MEMORY_TYPE == `BWD_MT_A3_DRAM) ||
			(AREA23_MEMORY_TYPE == `BWD_MT_A23_DRAM);
		a2_dram = (AREA23_MEMORY_TYPE == `BWD_MT_A23_DRAM);
		width_bad = width_check(width_cfg_ff, PORT_AB_USED);
		status_word = {a2_dram, dram_cfg_ff[`BWD_EXT_BIT] & a3_dram, a3_timing.rsvd_code, width_bad};
	end

	// read mux; unmapped offsets answer zero
	always_comb begin
		rd_word = 16'h0000;
		case (WB_ADR_I)
			`BWD_ADR_WIDTH_CFG: rd_word = width_cfg_ff;
			`BWD_ADR_DRAM_CFG: rd_word = dram_cfg_ff;
			`BWD_ADR_IDLE_CFG: rd_word = idle_cfg_ff;
			`BWD_ADR_STATUS: rd_word = {12'h000, status_word};
			default: rd_word = 16'h0000;
		endcase
	end

	// ack one cycle after the request, dropped the cycle after
	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= req & ~ack_ff;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			rdata_ff <= 32'h0000_0000;
		end else if (req & ~ack_ff) begin
			rdata_ff <= {16'h0000, rd_word};
		end
	end

	// timing for areas 3 and 2 of the dma-side controller
	bwd_dram_timing_sel #(
		.AREA2_STYLE (1'b0)
	) u_area3 (
		.ext_mode           (dram_cfg_ff[`BWD_EXT_BIT]),
		.is_dram            (a3_dram),
		.after_self_refresh (AFTER_SELF_REFRESH),
		.ext_fields         (dram_cfg_ff[`BWD_A3_FIELDS_MSB:`BWD_A3_FIELDS_LSB]),
		.cpu_fields         (MEMORY_CONTROL_FIELDS),
		.timing             (a3_timing)
	);

	bwd_dram_timing_sel #(
		.AREA2_STYLE (1'b1)
	) u_area2 (
		.ext_mode           (dram_cfg_ff[`BWD_EXT_BIT]),
		.is_dram            (a2_dram),
		.after_self_refresh (AFTER_SELF_REFRESH),
		.ext_fields         (dram_cfg_ff[`BWD_A2_FIELDS_MSB:`BWD_A2_FIELDS_LSB]),
		.cpu_fields         (DRAM_CONTROL_FIELDS),
		.timing             (a2_timing)
	);

	// dma-side snapshot at cycle start so a running cycle keeps its timing
	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			dma_ext_ff <= 1'b0;
			dma_a3_ff <= '0;
			dma_a2_ff <= '0;
		end else if (DMA_CYCLE_START) begin
			dma_ext_ff <= dram_cfg_ff[`BWD_EXT_BIT];
			dma_a3_ff <= a3_timing;
			dma_a2_ff <= a2_timing;
		end
	end

	// short pitch in extended mode for any ras-cas delay code; single minimum grows with the code
	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			dma_single_ff <= `BWD_EXT_SINGLE_MIN;
			dma_pitch_ff <= `BWD_EXT_BURST_PITCH;
		end else if (DMA_CYCLE_START) begin
			if (dram_cfg_ff[`BWD_EXT_BIT]) begin
				dma_single_ff <= `BWD_EXT_SINGLE_MIN + a3_timing.ras_cas - `BWD_RCD_BASE;
				dma_pitch_ff <= `BWD_EXT_BURST_PITCH;
			end else begin
				// normal mode: the cpu-side rules own the pacing
				dma_single_ff <= `BWD_EXT_SINGLE_MIN + a3_timing.ras_cas;
				dma_pitch_ff <= `BWD_EXT_SINGLE_MIN;
			end
		end
	end

	// width snapshot at any bus cycle start
	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			area_width_ff <= `BWD_RST_AREA_WIDTH;
			width_rsvd_ff <= 1'b0;
		end else if (BUS_CYCLE.start) begin
			area_width_ff <= width_cfg_ff[`BWD_WIDTH_MSB:`BWD_WIDTH_LSB];
			width_rsvd_ff <= width_bad;
		end
	end

	// idle need: left the previous area, or read followed by write in it
	always_comb begin
		need_idle = prev_valid_ff &&
			((BUS_CYCLE.area != prev_area_ff) || (prev_read_ff && BUS_CYCLE.write));
		idle_code = idle_field(idle_cfg_ff, prev_area_ff);
	end

	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			prev_valid_ff <= 1'b0;
			prev_area_ff <= 3'h0;
			prev_read_ff <= 1'b0;
		end else if (BUS_CYCLE.start) begin
			prev_valid_ff <= 1'b1;
			prev_area_ff <= BUS_CYCLE.area;
			prev_read_ff <= ~BUS_CYCLE.write;
		end
	end

	// a field-less area yields no idle even when switching away
	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			idle_cycles_ff <= `BWD_NO_IDLE;
			idle_insert_ff <= 1'b0;
		end else if (BUS_CYCLE.start) begin
			if (need_idle && (idle_field(`BWD_WMASK_IDLE_CFG, prev_area_ff) != `BWD_NO_IDLE)) begin
				idle_cycles_ff <= idle_count(idle_code);
				idle_insert_ff <= 1'b1;
			end else begin
				idle_cycles_ff <= `BWD_NO_IDLE;
				idle_insert_ff <= 1'b0;
			end
		end else begin
			idle_insert_ff <= 1'b0;
		end
	end

	// outputs straight from flip-flops
	assign WB_DAT_O = rdata_ff;
	assign WB_ACK_O = ack_ff;
	assign AREA_WIDTH = area_width_ff;
	assign WIDTH_RESERVED = width_rsvd_ff;
	assign IDLE_CYCLES = idle_cycles_ff;
	assign IDLE_INSERT = idle_insert_ff;
	assign DMA_EXTENDED = dma_ext_ff;
	assign DMA_SINGLE_MIN = dma_single_ff;
	assign DMA_BURST_PITCH = dma_pitch_ff;
	assign DMA_AREA3_TIMING = dma_a3_ff;
	assign DMA_AREA2_TIMING = dma_a2_ff;
endmodule

// ==== test/bwd_regs_chk.sv ====
// assertions on the ports of the register bank
// assumes bwd_regs on one clock with synchronous reset
`timescale 1ns/1ps
module bwd_regs_chk import bwd_pkg::*; (
	// clock and reset
	input wire logic             REF_CLK,
	input wire logic             SRST,
	// register bus
	input wire logic             WB_CYC_I,
	input wire logic             WB_STB_I,
	input wire logic             WB_WE_I,
	input wire logic [7:0]       WB_ADR_I,
	input wire logic [31:0]      WB_DAT_O,
	input wire logic             WB_ACK_O,
	// bus cycle side
	input wire bwd_bus_cycle_t   BUS_CYCLE,
	input wire logic             DMA_CYCLE_START,
	input wire logic [9:0]       AREA_WIDTH,
	input wire logic [1:0]       IDLE_CYCLES,
	input wire logic             IDLE_INSERT,
	input wire logic             DMA_EXTENDED,
	input wire logic [2:0]       DMA_SINGLE_MIN,
	input wire logic [2:0]       DMA_BURST_PITCH,
	input wire bwd_dram_timing_t DMA_AREA3_TIMING,
	input wire bwd_dram_timing_t DMA_AREA2_TIMING
);
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (SRST);
	wire rd = WB_ACK_O && !WB_WE_I;
	AST_ACK_NEXT: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
		else $error("no ack after request");
	AST_ACK_ONCE: assert property (WB_ACK_O |=> !WB_ACK_O)
		else $error("ack longer than one cycle");
	AST_WIDTH_ZERO: assert property (rd && WB_ADR_I == 8'h00 |->
		WB_DAT_O[31:14] == 18'h0 && WB_DAT_O[3:0] == 4'h0) else $error("width fixed bits set");
	AST_IDLE_ZERO: assert property (rd && WB_ADR_I == 8'h08 |->
		WB_DAT_O[15:14] == 2'h0 && WB_DAT_O[3:2] == 2'h0) else $error("idle fixed bits set");
	AST_DRAM_ZERO: assert property (rd && WB_ADR_I == 8'h04 |->
		WB_DAT_O[14] == 1'b0 && WB_DAT_O[7:6] == 2'h0) else $error("dram fixed bits set");
	AST_IDLE_CAUSE: assert property (IDLE_INSERT |-> $past(BUS_CYCLE.start) && IDLE_CYCLES != 2'h0)
		else $error("idle without start or count");
	AST_HOLD: assert property (!BUS_CYCLE.start |=> $stable(AREA_WIDTH) && $stable(IDLE_CYCLES))
		else $error("settings moved mid cycle");
	AST_DMA_HOLD: assert property (!DMA_CYCLE_START |=> $stable(DMA_AREA2_TIMING) && $stable(DMA_EXTENDED))
		else $error("dma settings moved mid cycle");
	AST_EXT_PITCH: assert property (DMA_EXTENDED |-> DMA_BURST_PITCH == 3'h1 && DMA_SINGLE_MIN >= 3'h2)
		else $error("extended pitch wrong");
	AST_A3_RANGE: assert property ($past(DMA_CYCLE_START) |-> DMA_AREA3_TIMING.ras_cas inside {[3'h1:3'h4]}
		&& DMA_AREA3_TIMING.refresh_ras inside {[3'h2:3'h5]}) else $error("area3 timing range");
	AST_A2_PRE: assert property ($past(DMA_CYCLE_START) |->
		DMA_AREA2_TIMING.precharge inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h8, 4'hB}) else $error("area2 precharge");
endmodule

bind bwd_regs bwd_regs_chk i_chk (.REF_CLK(REF_CLK), .SRST(SRST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
	.WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .BUS_CYCLE(BUS_CYCLE),
	.DMA_CYCLE_START(DMA_CYCLE_START), .AREA_WIDTH(AREA_WIDTH), .IDLE_CYCLES(IDLE_CYCLES),
	.IDLE_INSERT(IDLE_INSERT), .DMA_EXTENDED(DMA_EXTENDED), .DMA_SINGLE_MIN(DMA_SINGLE_MIN),
	.DMA_BURST_PITCH(DMA_BURST_PITCH), .DMA_AREA3_TIMING(DMA_AREA3_TIMING), .DMA_AREA2_TIMING(DMA_AREA2_TIMING));

// ==== test/tb_bwd_regs.sv ====
// self-checking bench for the register bank
// assumes bwd_regs and its checker compiled before it
`timescale 1ns/1ps
module tb_bwd_regs import bwd_pkg::*; ();
	logic             clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, port = 0, asr = 0, dst = 0, e;
	logic [7:0]       adr = 0;
	logic [3:0]       sel = 0;
	logic [31:0]      wd = 0, r;
	logic [2:0]       mt = 0;
	bwd_ctl_fields_t  mcf = 0, dcf = 0, f2, f3;
	bwd_bus_cycle_t   bc = 0;
	wire [31:0]       rdat;
	wire              ack, wres, ext, iins;
	wire [9:0]        aw;
	wire [1:0]        icyc;
	wire [2:0]        smin, pit;
	wire bwd_dram_timing_t t3, t2;
	int               errors = 0, compares = 0, pa = -1;
	bit               pw;
	logic [1:0]       wc, tp, tr;
	logic [15:0]      exp_q[$], idle_v = 16'h3FF3;
	logic [1:0]       idle_q[$];
	logic [7:0]       a3[3] = '{8'h00, 8'h04, 8'h08};
	logic [15:0]      m3[3] = '{16'h3FF0, 16'hBF3F, 16'h3FF3};

	bwd_regs i_dut (.REF_CLK(clk), .SRST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
		.WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wd), .WB_DAT_O(rdat), .WB_ACK_O(ack),
		.PORT_AB_USED(port), .AREA23_MEMORY_TYPE(mt), .MEMORY_CONTROL_FIELDS(mcf),
		.DRAM_CONTROL_FIELDS(dcf), .AFTER_SELF_REFRESH(asr), .BUS_CYCLE(bc), .DMA_CYCLE_START(dst),
		.AREA_WIDTH(aw), .WIDTH_RESERVED(wres), .IDLE_CYCLES(icyc), .IDLE_INSERT(iins),
		.DMA_EXTENDED(ext), .DMA_SINGLE_MIN(smin), .DMA_BURST_PITCH(pit), .DMA_AREA3_TIMING(t3),
		.DMA_AREA2_TIMING(t2));

	always #20 clk = ~clk;

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// classic cycle, no fixed latency assumed
	task automatic wb(input logic [7:0] a, input bit w, input logic [15:0] d, input logic [3:0] s);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		wd <= {16'h0, d};
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (n == 50) errors++;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		if (a == 8'h08) idle_v = d & 16'h3FF3;
		wb(a, 1'b1, d, 4'h3);
	endtask

	task automatic rd(input logic [7:0] a, input logic [15:0] x);
		exp_q.push_back(x);
		wb(a, 1'b0, 16'h0, 4'h3);
	endtask

	// power-on reset mid-run, a check that dram timing cleared, then the width init write software owes
	task automatic por();
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		idle_v = 16'h3FF3;
		pa = -1;
		rd(8'h04, 16'h0000);
		wr(8'h00, 16'h3FF0);
	endtask

	// idle expectation from the area being left
	task automatic start(input logic [2:0] a, input bit w);
		int f;
		if (pa >= 0 && pa != 1 && pa != 7 && (pa != a || (!pw && w))) begin
			f = (idle_v >> (2 * pa)) & 3;
			idle_q.push_back(f < 2 ? 2'h1 : f[1:0]);
		end
		@(posedge clk);
		bc <= '{1'b1, a, w};
		@(posedge clk);
		bc.start <= 1'b0;
		pa = a;
		pw = w;
		@(posedge clk);
	endtask

	function automatic bwd_dram_timing_t tm(input bwd_ctl_fields_t f, input bit sr);
		tm.precharge = sr ? 4'h2 + 4'h3 * f.tpc : 4'h1 + f.tpc;
		tm.ras_cas = 3'h1 + f.rcd;
		tm.refresh_ras = 3'h2 + f.tras;
		tm.rsvd_code = 1'b0;
	endfunction

	always @(posedge clk) if (ack === 1'b1 && we === 1'b0) chk(rdat[15:0], exp_q.pop_front());
	always @(posedge clk) if (iins === 1'b1) chk(icyc, idle_q.pop_front());

	task automatic final_report();
		if (exp_q.size() != 0 || idle_q.size() != 0) errors++;
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// generous bound, the run needs well under a tenth of it
	initial begin
		#1ms;
		errors++;
		final_report();
	end

	initial begin
		void'($urandom(32'hC7918BE8));
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		chk(aw, 10'h3FF);
		chk(t3, 11'h0);
		chk(pit, 3'h1);
		rd(8'h00, 16'h3FF0);
		rd(8'h04, 16'h0000);
		rd(8'h08, 16'h3FF3);
		rd(8'h10, 16'h0000);
		$display("reset values done");
		for (int i = 0; i < 9; i++) begin
			r = i < 3 ? 32'hFFFF : $urandom;
			// widths stay legal for unused port pins; dram reserved bits written zero
			if (i % 3 == 0) r = r | 32'h1550;
			if (i % 3 == 1) r = r & 32'hBF3F;
			if (i % 3 == 1) por();
			wr(a3[i % 3], r[15:0]);
			rd(a3[i % 3], r[15:0] & m3[i % 3]);
		end
		wb(8'h08, 1'b1, 16'h0000, 4'h1);
		idle_v = idle_v & 16'hFF00;
		rd(8'h08, idle_v);
		$display("register access done");
		for (int c = 0; c < 8; c++) begin
			// no reserved code, and no 32-bit while the port pins are shared
			wc = c[1:0] == 2'h0 ? 2'h1 : ((c[2] && c[1:0] == 2'h3) ? 2'h2 : c[1:0]);
			wr(8'h00, {2'h0, {5{wc}}, 4'h0});
			port <= c[2];
			start(3'h0, 1'b0);
			chk(aw, {5{wc}});
			chk(wres, 1'b0);
		end
		port <= 1'b0;
		$display("width codes done");
		for (int i = 0; i < 48; i++) begin
			r = $urandom;
			if (i % 8 == 0) wr(8'h08, r[31:16]);
			start(r[2:0], r[3]);
		end
		$display("idle insertion done");
		for (int k = 0; k < 8; k++) begin
			r = $urandom;
			por();
			// precharge and refresh fields agree in all four places
			tp = {1'b0, r[0]};
			tr = r[2:1];
			f2 = {tp, r[4:3], tr};
			f3 = {tp, r[6:5], tr};
			e = k[0];
			mcf <= {tp, r[8:7], tr};
			dcf <= {tp, r[10:9], tr};
			mt <= 3'h4 + k[1];
			asr <= k[2];
			wr(8'h04, {e, 1'b0, f3, 2'h0, f2});
			@(posedge clk);
			dst <= 1'b1;
			@(posedge clk);
			dst <= 1'b0;
			@(posedge clk);
			chk(ext, e);
			chk(t3, tm(e ? f3 : mcf, 1'b0));
			chk(t2, tm(e && k[1] ? f2 : dcf, asr));
			if (e) chk(pit, 3'h1);
			chk(smin, e ? 3'h2 + f3.rcd : 3'h3 + mcf.rcd);
			rd(8'h0C, {12'h000, k[1], e, 2'h0});
		end
		$display("dma timing done");
		repeat (4) @(posedge clk);
		final_report();
	end
endmodule
